// file: core/adc_ctrl.sv
// Converter control: APB registers, prescaler, triggering, sequencing.
// Assumes the analog front end compares against dac_code each tick.
`timescale 1ns/10ps
module adc_ctrl #(
  parameter int NTRIG = adc_ctrl_pkg::NTRIG
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Event sources from other blocks, index 0 unused
  input  wire logic [NTRIG-1:0]            trig_src,
  // Analog front end
  input  wire logic                        comp_above,
  output logic      [adc_ctrl_pkg::RES_W-1:0] dac_code,
  output adc_ctrl_pkg::mux_sel_t           mux_sel,
  output logic                             analog_on,
  output logic                             sample_hold,
  output logic                             conv_done
);

  initial begin
    if (NTRIG != (1 << adc_ctrl_pkg::TS_W))
      $error("adc_ctrl: NTRIG must match trigger_select width");
  end

  // ----------------------------------------------------------------------
  // Software visible state
  // ----------------------------------------------------------------------
  logic [adc_ctrl_pkg::CH_W-1:0]  chan_q;      // Temporary channel select
  logic [adc_ctrl_pkg::REF_W-1:0] ref_q;       // Temporary reference
  logic                           ladj_q;      // left_adjust
  logic [adc_ctrl_pkg::PS_W-1:0]  ps_q;        // prescaler_select
  logic                           flag_q;      // conversion_complete_flag
  logic                           ate_q;       // auto_trigger_enable
  logic                           start_q;     // start_conversion
  logic                           en_q;        // adc_enable
  logic [adc_ctrl_pkg::TS_W-1:0]  ts_q;        // trigger_select
  logic [adc_ctrl_pkg::RES_W-1:0] res_q;       // Held result
  logic                           lock_q;      // Result update block
  adc_ctrl_pkg::mux_sel_t         sel_q;       // Selection in use

  // Converter sequencing
  adc_ctrl_pkg::conv_state_t      state_q;
  logic [adc_ctrl_pkg::PRE_W-1:0] pre_q;       // Prescaler counter
  logic [4:0]                     cyc_q;       // Converter cycles elapsed
  logic [4:0]                     len_q;       // Length of this conversion
  logic [4:0]                     sh_q;        // Sample instant
  logic                           first_q;     // Next conversion is first
  logic                           pend_q;      // Software start pending
  logic                           single_q;    // Current one is single
  logic [1:0]                     tsync_q;     // Trigger synchroniser
  logic                           tprev_q;     // Trigger edge history
  logic                           sh_q_out;
  logic                           done_q;
  logic [31:0]                    prdata_q;
  logic                           pready_q;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic acc;        // Access phase, completes this edge
  logic wr;
  logic rd;
  assign acc = psel && penable && pready_q;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;

  logic wr_csa;
  logic start_wr;
  logic rd_lo;
  logic rd_hi;
  assign wr_csa   = wr && paddr == adc_ctrl_pkg::OFS_CSA;
  assign start_wr = wr_csa && pwdata[adc_ctrl_pkg::CSA_START] &&
                    (en_q || pwdata[adc_ctrl_pkg::CSA_EN]);
  assign rd_lo    = rd && paddr == adc_ctrl_pkg::OFS_RES_LO;
  assign rd_hi    = rd && paddr == adc_ctrl_pkg::OFS_RES_HI;

  // Ready one cycle after the setup phase: no wait states, access completes in its first cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel && !pready_q;
    end
  end

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  logic tick;       // One converter clock rising edge
  logic trig_edge;
  logic [adc_ctrl_pkg::PRE_W-1:0] pre_max;
  assign pre_max = (ps_q == 3'h0) ? 7'h01
                 : adc_ctrl_pkg::PRE_W'((8'h01 << ps_q) - 8'h01);
  assign tick    = en_q && pre_q == pre_max;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (!en_q || (trig_edge && state_q == adc_ctrl_pkg::ST_IDLE)) begin
      pre_q <= '0;
    end else if (tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Auto trigger edge detect
  // ----------------------------------------------------------------------
  logic trig_lvl;
  // source select, flag in slot 0
  assign trig_lvl  = (ts_q == adc_ctrl_pkg::TS_FLAG) ? flag_q
                   : tsync_q[1];
  // edge only, busy edges dropped below
  assign trig_edge = ate_q && en_q && trig_lvl && !tprev_q;

  // External events are synchronised; the flag is already local
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsync_q <= 2'b00;
      tprev_q <= 1'b0;
    end else begin
      tsync_q <= {tsync_q[0], trig_src[ts_q]};
      tprev_q <= trig_lvl;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  logic conv_start; // Conversion begins this cycle
  logic last_tick;  // Final converter cycle ends
  logic free_run;
  // flag as source repeats regardless of clearing
  assign free_run   = ate_q && ts_q == adc_ctrl_pkg::TS_FLAG;
  // software start waits for converter clock
  assign conv_start = state_q == adc_ctrl_pkg::ST_IDLE && en_q &&
                      ((pend_q && tick) ||
                       (trig_edge && ts_q != adc_ctrl_pkg::TS_FLAG));
  assign last_tick  = state_q == adc_ctrl_pkg::ST_CONV && tick &&
                      cyc_q == len_q - 5'd1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= adc_ctrl_pkg::ST_IDLE;
      cyc_q    <= '0;
      len_q    <= adc_ctrl_pkg::CYC_NORMAL;
      sh_q     <= adc_ctrl_pkg::SH_NORMAL;
      first_q  <= 1'b1;
      single_q <= 1'b0;
    end else if (!en_q) begin
      state_q <= adc_ctrl_pkg::ST_IDLE;
      first_q <= 1'b1;
    end else begin
      case (state_q)
        adc_ctrl_pkg::ST_IDLE: begin
          if (conv_start) begin
            state_q  <= adc_ctrl_pkg::ST_CONV;
            cyc_q    <= '0;
            single_q <= pend_q;
            first_q  <= 1'b0;
            len_q    <= first_q ? adc_ctrl_pkg::CYC_FIRST
                                : adc_ctrl_pkg::CYC_NORMAL;
            sh_q     <= first_q ? adc_ctrl_pkg::SH_FIRST
                      : pend_q  ? adc_ctrl_pkg::SH_NORMAL
                                : adc_ctrl_pkg::SH_AUTO;
          end
        end
        adc_ctrl_pkg::ST_CONV: begin
          if (last_tick) begin
            state_q <= adc_ctrl_pkg::ST_DONE;
          end else if (tick) begin
            cyc_q <= cyc_q + 5'd1;
          end
        end
        adc_ctrl_pkg::ST_DONE: begin
          if (free_run) begin
            state_q <= adc_ctrl_pkg::ST_CONV;
            cyc_q   <= '0;
            len_q   <= adc_ctrl_pkg::CYC_NORMAL;
            sh_q    <= adc_ctrl_pkg::SH_NORMAL;
          end else begin
            state_q <= adc_ctrl_pkg::ST_IDLE;
          end
          single_q <= 1'b0;
        end
        default: state_q <= adc_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // Pending software start, taken at the next converter clock edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
    end else if (!en_q || conv_start) begin
      pend_q <= start_wr && !conv_start;
    end else if (start_wr && state_q == adc_ctrl_pkg::ST_IDLE) begin
      pend_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Sample-and-hold strobe, half a converter clock after a whole count
  // ----------------------------------------------------------------------
  logic half;
  assign half = pre_q == (pre_max >> 1);
  // sample at whole plus half cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q_out <= 1'b0;
    end else begin
      sh_q_out <= en_q && state_q == adc_ctrl_pkg::ST_CONV && half &&
                  cyc_q == sh_q;
    end
  end

  // ----------------------------------------------------------------------
  // Binary search, one bit per converter cycle after sampling
  // ----------------------------------------------------------------------
  logic [adc_ctrl_pkg::RES_W-1:0] code;
  adc_sar_core #(
    .WIDTH (adc_ctrl_pkg::RES_W)
  ) u_sar (
    .pclk       (pclk),
    .presetn    (presetn),
    .begin_p    (sh_q_out),
    .step_p     (tick && state_q == adc_ctrl_pkg::ST_CONV && cyc_q > sh_q),
    .comp_above (comp_above),
    .trial      (dac_code),
    .code       (code)
  );

  // ----------------------------------------------------------------------
  // Selection latch
  // ----------------------------------------------------------------------
  // follows temporary register while enabled, except mid conversion
  // channel change held until the final converter cycle of a conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= '0;
    end else if (en_q && (state_q != adc_ctrl_pkg::ST_CONV ||
                          (tick && cyc_q == len_q - 5'd2))) begin
      sel_q <= '{ref_sel: ref_q, ch_sel: chan_q};
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_q <= '0;
      ref_q  <= '0;
      ladj_q <= 1'b0;
      ps_q   <= '0;
      ate_q  <= 1'b0;
      en_q   <= 1'b0;
      ts_q   <= '0;
    end else if (wr) begin
      case (paddr)
        adc_ctrl_pkg::OFS_MUX: begin
          chan_q <= pwdata[adc_ctrl_pkg::MUX_CH_LSB +: adc_ctrl_pkg::CH_W];
          ref_q  <= pwdata[adc_ctrl_pkg::MUX_REF_LSB +: adc_ctrl_pkg::REF_W];
          ladj_q <= pwdata[adc_ctrl_pkg::MUX_LADJ];
        end
        adc_ctrl_pkg::OFS_CSA: begin
          ps_q  <= pwdata[adc_ctrl_pkg::CSA_PS_LSB +: adc_ctrl_pkg::PS_W];
          ate_q <= pwdata[adc_ctrl_pkg::CSA_ATE];
          en_q  <= pwdata[adc_ctrl_pkg::CSA_EN];
        end
        adc_ctrl_pkg::OFS_CSB: begin
          ts_q <= pwdata[adc_ctrl_pkg::CSB_TS_LSB +: adc_ctrl_pkg::TS_W];
        end
        default: ;
      endcase
    end
  end

  // Start bit: set by software or any conversion start, held while busy, cleared at end unless free running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
    end else if (!en_q && !start_wr) begin
      start_q <= 1'b0;
    end else if (start_wr || conv_start) begin
      start_q <= 1'b1;
    end else if (state_q == adc_ctrl_pkg::ST_DONE && !free_run) begin
      start_q <= 1'b0;
    end
  end

  // Completion flag, set wins over the write-one clear
  // Set one cycle after the last tick, together with the result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (done_q) begin
      flag_q <= 1'b1;
    end else if (wr_csa && pwdata[adc_ctrl_pkg::CSA_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  // Result and read lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q  <= '0;
      lock_q <= 1'b0;
    end else begin
      // discard while blocked; taken one cycle after the last tick
      // so the final search step of an auto-triggered conversion counts
      if (done_q && !lock_q) begin
        res_q <= code;
      end
      // high read releases, low read blocks
      if (rd_hi) begin
        lock_q <= 1'b0;
      end else if (rd_lo) begin
        lock_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [15:0] res_al;
  assign res_al = ladj_q ? {res_q, 6'h00} : {6'h00, res_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        adc_ctrl_pkg::OFS_MUX:
          prdata_q <= {24'h0, ref_q, ladj_q, 2'h0, chan_q};
        adc_ctrl_pkg::OFS_CSA:
          prdata_q <= {24'h0, en_q, start_q, ate_q, flag_q, 1'h0, ps_q};
        adc_ctrl_pkg::OFS_CSB:    prdata_q <= {29'h0, ts_q};
        adc_ctrl_pkg::OFS_RES_LO: prdata_q <= {24'h0, res_al[7:0]};
        adc_ctrl_pkg::OFS_RES_HI: prdata_q <= {24'h0, res_al[15:8]};
        default:                  prdata_q <= '0;
      endcase
    end
  end

  // Conversion done pulse for the front end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= last_tick;
    end
  end

  // Outputs
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = 1'b0;
  assign mux_sel     = sel_q;
  assign analog_on   = en_q;
  assign sample_hold = sh_q_out;
  assign conv_done   = done_q;

endmodule

// file: common/adc_ctrl_pkg.sv
// Constants, register map and field layout for the converter control block.
// Assumes a 32-bit APB slave with one aligned word per register.
package adc_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_MUX    = 8'h00;  // mux_select_reg
  localparam logic [7:0] OFS_CSA    = 8'h04;  // control_status_a
  localparam logic [7:0] OFS_CSB    = 8'h08;  // control_status_b
  localparam logic [7:0] OFS_RES_LO = 8'h0C;  // result_low
  localparam logic [7:0] OFS_RES_HI = 8'h10;  // result_high

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  // mux_select_reg
  localparam int MUX_CH_LSB  = 0;   // channel_select [2:0]
  localparam int MUX_LADJ    = 5;   // left_adjust
  localparam int MUX_REF_LSB = 6;   // reference_select [7:6]
  // control_status_a
  localparam int CSA_PS_LSB  = 0;   // prescaler_select [2:0]
  localparam int CSA_FLAG    = 4;   // conversion_complete_flag, W1C
  localparam int CSA_ATE     = 5;   // auto_trigger_enable
  localparam int CSA_START   = 6;   // start_conversion
  localparam int CSA_EN      = 7;   // adc_enable
  // control_status_b
  localparam int CSB_TS_LSB  = 0;   // trigger_select [2:0]

  // ----------------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------------
  localparam int RES_W    = 10;     // Result width
  localparam int CH_W     = 3;      // Channel select width
  localparam int REF_W    = 2;      // Reference select width
  localparam int PS_W     = 3;      // Prescaler select width
  localparam int TS_W     = 3;      // Trigger select width
  localparam int NTRIG    = 8;      // Trigger sources
  localparam int PRE_W    = 7;      // Prescaler counter width (max /128)
  // Conversion lengths in converter clock cycles
  localparam logic [4:0] CYC_NORMAL = 5'd13;
  localparam logic [4:0] CYC_FIRST  = 5'd25;
  // Sample point, whole converter cycles after start (half cycle on top)
  localparam logic [4:0] SH_NORMAL  = 5'd1;
  localparam logic [4:0] SH_FIRST   = 5'd13;
  localparam logic [4:0] SH_AUTO    = 5'd2;
  // Trigger source index reserved for the completion flag
  localparam logic [TS_W-1:0] TS_FLAG = 3'h0;

  // Selection carried from the temporary register into the converter
  typedef struct packed {
    logic [REF_W-1:0] ref_sel;
    logic [CH_W-1:0]  ch_sel;
  } mux_sel_t;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b10
  } conv_state_t;

endpackage

// file: core/adc_sar_core.sv
// Successive approximation register: one bit decided per converter tick.
// Assumes the analog comparator answers within the tick it is asked.
`timescale 1ns/10ps
module adc_sar_core #(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             begin_p,     // Clear and start the search
  input  wire logic             step_p,      // Decide one bit
  // Analog comparator
  input  wire logic             comp_above,  // Input above trial code
  output logic      [WIDTH-1:0] trial,       // Code under test
  output logic      [WIDTH-1:0] code         // Settled code
);

  initial begin
    if (WIDTH < 2) $error("adc_sar_core: WIDTH too small");
  end

  logic [WIDTH-1:0] bit_q;   // Bit currently under test
  logic [WIDTH-1:0] acc_q;   // Accepted bits
  logic [WIDTH-1:0] trial_q; // Code under test, straight from a register
  logic [WIDTH-1:0] keep;    // Accepted bits after this step

  // ----------------------------------------------------------------------
  // Binary search
  // ----------------------------------------------------------------------
  assign keep  = comp_above ? (acc_q | bit_q) : acc_q;
  assign trial = trial_q;
  assign code  = acc_q;

  // Each step keeps the trial bit when the input lies above it; the next
  // trial is formed here so the comparator never sees a gated code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_q   <= '0;
      acc_q   <= '0;
      trial_q <= '0;
    end else if (begin_p) begin
      bit_q   <= {1'b1, {(WIDTH-1){1'b0}}};
      acc_q   <= '0;
      trial_q <= {1'b1, {(WIDTH-1){1'b0}}};
    end else if (step_p && bit_q != '0) begin
      acc_q   <= keep;
      bit_q   <= bit_q >> 1;
      trial_q <= keep | (bit_q >> 1);
    end
  end

endmodule

// file: bench/adc_ctrl_sva.sv
// Port checker for the converter control block.
// Assumes one clock pclk and async active-low presetn.
`timescale 1ns/10ps
module adc_ctrl_sva #(
  parameter int NTRIG = adc_ctrl_pkg::NTRIG
) (
  // Clock, reset and APB
  input wire logic        pclk, presetn, psel, penable, pwrite, pready,
  input wire logic        pslverr,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  // Converter side
  input wire logic        analog_on, sample_hold, conv_done,
  input wire adc_ctrl_pkg::mux_sel_t mux_sel
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_access: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  a_no_error: assert property (pready |-> !pslverr)
    else $error("slave error raised");
  a_unmapped_zero: assert property (psel && !penable && !pwrite
    && paddr > 8'h10 |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_enable_write:
    assert property (psel && penable && pready && pwrite
    && paddr == adc_ctrl_pkg::OFS_CSA |=> analog_on == $past(pwdata[7]))
    else $error("enable does not follow write");
  a_off_quiet:
    assert property (!analog_on [*2] |-> !sample_hold && !conv_done)
    else $error("activity while disabled");
  a_sel_frozen_off:
    assert property (!analog_on [*2] |-> $stable(mux_sel))
    else $error("selection moved while disabled");
  a_sel_locked:
    assert property (sample_hold |=> $stable(mux_sel) [*8])
    else $error("selection moved in conversion");
  a_done_pulse:
    assert property (conv_done |=> !conv_done && !sample_hold)
    else $error("completion pulse too long");
  // Main scenarios reached
  c_sample: cover property (sample_hold);
  c_done: cover property (conv_done);
  c_read_hi: cover property (pready && !pwrite && paddr == 8'h10);
endmodule
bind adc_ctrl adc_ctrl_sva #(.NTRIG(NTRIG)) adc_ctrl_sva_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .analog_on(analog_on),
  .sample_hold(sample_hold), .conv_done(conv_done), .mux_sel(mux_sel));

// file: bench/tb.sv
// Self-checking bench for the converter control block.
// Assumes APB answers in the access cycle and converter clock is pclk/2, or pclk/8 in the 8'hC3 run.
`timescale 1ns/10ps
`define CHK(n,e,s) begin checks_done++; if ((s) !== (e)) begin num_errors++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
  logic        pclk, presetn, psel, penable, pwrite, comp_above;
  logic        pready, pslverr, analog_on, sample_hold, conv_done;
  logic [7:0]  paddr, trig_src;
  logic [31:0] pwdata, prdata, rd, lfsr;
  logic [9:0]  dac_code, vin, va;
  adc_ctrl_pkg::mux_sel_t mux_sel;
  int          num_errors, checks_done, tcnt, t0, dones, d0;
  adc_ctrl adc_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_src(trig_src), .comp_above(comp_above), .dac_code(dac_code),
    .mux_sel(mux_sel), .analog_on(analog_on),
    .sample_hold(sample_hold), .conv_done(conv_done));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Input sits half an LSB above its code, so the search settles on vin
  always @(posedge pclk) begin
    comp_above <= (vin >= dac_code);
    tcnt <= tcnt + 1;
    if (conv_done === 1'b1) dones <= dones + 1;
    if (tcnt == 3000) begin
      num_errors++;
      print_verdict;
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Result placement: right aligned, or left with the high bits on top
  function automatic logic [15:0] place(input logic [9:0] v, input logic la);
    return la ? {v, 6'h00} : {6'h00, v};
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task go(input logic [7:0] csa);
    vin = lfsr[9:0];
    lfsr = nxt(lfsr);
    apb(1'b1, adc_ctrl_pkg::OFS_CSA, {24'h0, csa});
    t0 = tcnt;
  endtask
  // Window allows prescaler phase, pulse lag and trigger sync
  task wait_done(input int n);
    while (conv_done !== 1'b1 && tcnt - t0 < 400) @(posedge pclk);
    `CHK("conv_len", 1'b1, (tcnt-t0 >= 2*n-2 && tcnt-t0 <= 2*n+5))
    repeat (2) @(posedge pclk);
  endtask
  task res(input logic [15:0] e);
    apb(1'b0, adc_ctrl_pkg::OFS_RES_LO, 0);
    `CHK("res_low", e[7:0], rd[7:0])
    apb(1'b0, adc_ctrl_pkg::OFS_RES_HI, 0);
    `CHK("res_high", e[15:8], rd[7:0])
  endtask
  task print_verdict;
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; trig_src = 8'h00; comp_above = 1'b0;
    vin = 10'h000; lfsr = 32'h3DBEAE3D; tcnt = 0; dones = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 0);
      `CHK("reset_val", 32'h0, rd)
    end
    apb(1'b1, 8'h14, 32'hFF);
    apb(1'b1, adc_ctrl_pkg::OFS_MUX, 32'h45);
    go(8'h41);
    repeat (60) @(posedge pclk);
    `CHK("sel_off", 5'h00, mux_sel)
    `CHK("no_conv_off", 0, dones)
    apb(1'b1, adc_ctrl_pkg::OFS_CSA, 32'h81); // power assumed on
    repeat (2) @(posedge pclk);
    `CHK("sel_on", 5'h0D, mux_sel)
    go(8'hC1);
    wait_done(25);
    apb(1'b0, adc_ctrl_pkg::OFS_CSA, 0);
    `CHK("start_clr", 2'b01, {rd[6], rd[4]})
    res(place(vin, 1'b0));
    go(8'hD1);
    apb(1'b1, adc_ctrl_pkg::OFS_MUX, 32'h47);
    `CHK("sel_held", 5'h0D, mux_sel)
    wait_done(13);
    `CHK("sel_after", 5'h0F, mux_sel)
    va = vin;
    apb(1'b0, adc_ctrl_pkg::OFS_RES_LO, 0);
    go(8'hD1);
    wait_done(13);
    apb(1'b0, adc_ctrl_pkg::OFS_CSA, 0);
    `CHK("flag_lost", 1'b1, rd[4])
    res(place(va, 1'b0));
    apb(1'b1, adc_ctrl_pkg::OFS_MUX, 32'h67);
    go(8'hD1);
    wait_done(13);
    res(place(vin, 1'b1));
    apb(1'b1, adc_ctrl_pkg::OFS_CSB, 0);
    d0 = dones;
    go(8'hF1);
    repeat (100) @(posedge pclk);
    `CHK("free_run", 1'b1, (dones - d0 inside {[3:4]}))
    apb(1'b0, adc_ctrl_pkg::OFS_CSA, 0);
    `CHK("start_high", 1'b1, rd[6])
    apb(1'b1, adc_ctrl_pkg::OFS_CSA, 32'h91);
    repeat (60) @(posedge pclk);
    apb(1'b1, adc_ctrl_pkg::OFS_CSB, 1);
    apb(1'b1, adc_ctrl_pkg::OFS_CSA, 32'hB1); // flag cleared
    d0 = dones;
    trig_src <= 8'h02;
    t0 = tcnt;
    wait_done(14);
    repeat (60) @(posedge pclk);
    `CHK("held_trig", 1, dones - d0)
    res(place(vin, 1'b1));
    trig_src <= 8'h00;
    repeat (4) @(posedge pclk);
    trig_src <= 8'h02;
    repeat (12) @(posedge pclk);
    trig_src <= 8'h00;
    repeat (4) @(posedge pclk);
    trig_src <= 8'h02;
    repeat (80) @(posedge pclk);
    `CHK("busy_edge", 2, dones - d0)
    apb(1'b1, adc_ctrl_pkg::OFS_CSA, 32'h81);
    go(8'hC1);
    wait_done(13);
    go(8'hC3);
    wait_done(55);
    res(place(vin, 1'b1));
    apb(1'b1, adc_ctrl_pkg::OFS_CSA, 0);
    apb(1'b1, adc_ctrl_pkg::OFS_CSA, 32'h81);
    go(8'hC1);
    wait_done(25);
    print_verdict;
  end
endmodule
